// ===== rtl/mcpah_buf.sv
// Command data byte store, registered read port
module mcpah_buf (
   input wire logic ref_clk,
   input wire logic ce,
   input wire logic we,
   input wire logic [mcpah_pkg::BUF_AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [mcpah_pkg::BUF_AW-1:0] raddr,
   output logic [7:0] rdata
);

   logic [7:0] mem [0:(1 << mcpah_pkg::BUF_AW)-1];

   // No reset on the array; stale bytes are never read past the frame
   always_ff @(posedge ref_clk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end

endmodule : mcpah_buf

// ===== rtl/mcpah_pkg.sv
// Overview of operation
// - Type 04h select: power cycle, then card reset
// - Zoned select sets page write size 16
// - Successful replies other than verify end with 90h 00h
// - Zoned B0h user read, B1h config/fuse read
// - Zoned address bits 10..8 from zone byte
// - B1h with address 80h reads fuse
// - D0h user write, D1h config/fuse write
// - Read returns length bytes in address order
// - Selector nibble: read flag, set, 0111 secure
// - Verify reply 90h plus card retry counter
// - Type 05h select: cycle, reset, 10-bit family
// - Ten-bit B0h read, address from two bytes
package mcpah_pkg;

   // -------------------------------------------------------------
   // Command bytes and header layout
   // -------------------------------------------------------------
   localparam logic [7:0] CLA_PSEUDO = 8'hFF;
   localparam logic [7:0] INS_SELECT = 8'hA4;
   localparam logic [7:0] INS_READ_USER = 8'hB0;
   localparam logic [7:0] INS_READ_CFG = 8'hB1;
   localparam logic [7:0] INS_WRITE_USER = 8'hD0;
   localparam logic [7:0] INS_WRITE_CFG = 8'hD1;
   localparam logic [7:0] INS_VERIFY_PW = 8'h20;
   localparam logic [7:0] INS_AUTH_START = 8'h84;
   localparam logic [7:0] INS_AUTH_FINISH = 8'h82;
   localparam logic [7:0] TYPE_ZONED = 8'h04;
   localparam logic [7:0] TYPE_TENBIT = 8'h05;
   localparam logic [7:0] FUSE_ADDR = 8'h80;
   localparam logic [7:0] P_ZERO = 8'h00;
   localparam logic [7:0] LEN_SELECT = 8'h01;
   localparam logic [7:0] LEN_PW = 8'h04;
   localparam logic [7:0] LEN_AUTH = 8'h08;
   localparam logic [8:0] IDX_CLA = 9'h000;
   localparam logic [8:0] IDX_INS = 9'h001;
   localparam logic [8:0] IDX_P1 = 9'h002;
   localparam logic [8:0] IDX_P2 = 9'h003;
   localparam logic [8:0] IDX_LEN = 9'h004;
   localparam logic [8:0] HDR_LEN = 9'h005;
   localparam logic [8:0] RX_IDX_MAX = 9'h104;

   // -------------------------------------------------------------
   // Password selector and retry counter
   // -------------------------------------------------------------
   localparam int PW_READ_BIT = 3;
   localparam logic [3:0] PW_SEL_SECURE = 4'h7;
   localparam logic [7:0] CNT_SUCCESS = 8'hFF;
   localparam logic [7:0] CNT_LOCKED = 8'h00;

   // -------------------------------------------------------------
   // Page size and status words
   // -------------------------------------------------------------
   localparam logic [7:0] PAGE_DEFAULT = 8'h08;
   localparam logic [7:0] PAGE_ZONED = 8'h10;
   localparam logic [7:0] SW1_OK = 8'h90;
   localparam logic [15:0] SW_OK = 16'h9000;
   localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
   localparam logic [15:0] SW_BAD_P = 16'h6A86;
   localparam logic [15:0] SW_NO_TYPE = 16'h6985;
   localparam logic [15:0] SW_BAD_INS = 16'h6D00;
   localparam logic [15:0] SW_BAD_CLA = 16'h6E00;

   // -------------------------------------------------------------
   // Widths and types
   // -------------------------------------------------------------
   localparam int BUF_AW = 8;
   localparam int ADDR_W = 11;

   typedef enum logic [1:0] {FAM_NONE, FAM_ZONED, FAM_TENBIT} mcpah_family_t;

   typedef enum logic [3:0] {
      OP_NONE, OP_POWER_CYCLE, OP_RESET, OP_USER_READ, OP_CFG_READ, OP_FUSE_READ,
      OP_USER_WRITE, OP_CFG_WRITE, OP_FUSE_WRITE, OP_PW_BYTE, OP_AUTH_START,
      OP_AUTH_FINISH
   } mcpah_op_t;

endpackage : mcpah_pkg

// ===== rtl/mcpah_top.sv
module mcpah_top (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_last,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_last,
   input wire logic rsp_ready,
   input wire logic card_present,
   output logic card_req,
   output mcpah_pkg::mcpah_op_t card_op,
   output logic [mcpah_pkg::ADDR_W-1:0] card_addr,
   output logic [7:0] card_wdata,
   input wire logic card_ack,
   input wire logic [7:0] card_rdata,
   output logic card_pw_read,
   output logic [2:0] card_pw_set,
   output logic card_pw_secure,
   output mcpah_pkg::mcpah_family_t card_family,
   output logic [7:0] page_size,
   output logic [7:0] retry_counter,
   output logic pw_verified,
   output logic pw_locked
);

   typedef enum logic [3:0] {
      S_RX, S_DECODE, S_FETCH, S_LOAD, S_CARD, S_OUT, S_STATUS, S_SW1, S_SW2
   } mcpah_state_t;

   mcpah_state_t state;
   logic [8:0] rx_idx;
   logic [7:0] hdr_cla;
   logic [7:0] hdr_ins;
   logic [7:0] hdr_p1;
   logic [7:0] hdr_p2;
   logic [7:0] hdr_len;
   logic [7:0] data0;
   logic [7:0] cnt;
   logic [7:0] job_n;
   logic [mcpah_pkg::ADDR_W-1:0] job_base;
   logic job_mem;
   logic [15:0] sw;
   mcpah_pkg::mcpah_family_t pend_family;
   logic [7:0] buf_rdata;

   // -------------------------------------------------------------
   // Receive side and data store
   // -------------------------------------------------------------
   wire logic accept = cmd_valid && cmd_ready;
   wire logic in_data = rx_idx >= mcpah_pkg::HDR_LEN;
   wire logic buf_we = (state == S_RX) && accept && in_data && (rx_idx < mcpah_pkg::RX_IDX_MAX);
   wire logic [8:0] data_ofs = rx_idx - mcpah_pkg::HDR_LEN;
   wire logic [8:0] data_cnt = in_data ? data_ofs : 9'h000;
   wire logic [mcpah_pkg::BUF_AW-1:0] buf_waddr = data_ofs[mcpah_pkg::BUF_AW-1:0];

   mcpah_buf u_buf (
      .ref_clk(ref_clk),
      .ce(ce),
      .we(buf_we),
      .waddr(buf_waddr),
      .wdata(cmd_data),
      .raddr(cnt),
      .rdata(buf_rdata)
   );

   // -------------------------------------------------------------
   // Command decode
   // -------------------------------------------------------------
   wire logic fam_z = card_family == mcpah_pkg::FAM_ZONED;
   wire logic fam_t = card_family == mcpah_pkg::FAM_TENBIT;
   wire logic ins_b0 = hdr_ins == mcpah_pkg::INS_READ_USER;
   wire logic ins_b1 = hdr_ins == mcpah_pkg::INS_READ_CFG;
   wire logic ins_d0 = hdr_ins == mcpah_pkg::INS_WRITE_USER;
   wire logic ins_d1 = hdr_ins == mcpah_pkg::INS_WRITE_CFG;
   wire logic ins_as = hdr_ins == mcpah_pkg::INS_AUTH_START;
   wire logic ins_af = hdr_ins == mcpah_pkg::INS_AUTH_FINISH;
   wire logic is_sel = hdr_ins == mcpah_pkg::INS_SELECT;
   wire logic is_rd_z = fam_z && (ins_b0 || ins_b1);
   wire logic is_wr_z = fam_z && (ins_d0 || ins_d1);
   wire logic is_rd_t = fam_t && ins_b0;
   wire logic is_pw = fam_z && (hdr_ins == mcpah_pkg::INS_VERIFY_PW);
   wire logic is_auth = fam_z && (ins_as || ins_af);
   wire logic is_fuse = fam_z && (hdr_p2 == mcpah_pkg::FUSE_ADDR) && (ins_b1 || ins_d1);
   wire logic known = is_sel || is_rd_z || is_wr_z || is_rd_t || is_pw || is_auth;
   wire logic p_zero = (hdr_p1 == mcpah_pkg::P_ZERO) && (hdr_p2 == mcpah_pkg::P_ZERO);
   wire logic data_match = data_cnt == {1'b0, hdr_len};
   wire logic len_sel = (hdr_len == mcpah_pkg::LEN_SELECT) && data_match;
   wire logic len_pw = (hdr_len == mcpah_pkg::LEN_PW) && data_match;
   wire logic len_auth = (hdr_len == mcpah_pkg::LEN_AUTH) && data_match;
   wire logic len_mem = is_wr_z ? data_match : (data_cnt == 9'h000);
   wire logic len_ok = is_sel ? len_sel : is_pw ? len_pw : is_auth ? len_auth : len_mem;
   wire logic par_ok = (is_sel || is_pw || is_auth) ? p_zero : 1'b1;
   // Only the two documented card types may touch the card
   wire logic type_ok = !is_sel || (data0 == mcpah_pkg::TYPE_ZONED) ||
                        (data0 == mcpah_pkg::TYPE_TENBIT);
   wire logic [15:0] unknown_sw = (card_family == mcpah_pkg::FAM_NONE) ?
                                  mcpah_pkg::SW_NO_TYPE : mcpah_pkg::SW_BAD_INS;
   // Error priority: short frame, class, opcode, length, parameters
   wire logic [15:0] dec_sw = (rx_idx < mcpah_pkg::HDR_LEN) ? mcpah_pkg::SW_WRONG_LEN :
                              (hdr_cla != mcpah_pkg::CLA_PSEUDO) ? mcpah_pkg::SW_BAD_CLA :
                              !known ? unknown_sw :
                              !len_ok ? mcpah_pkg::SW_WRONG_LEN :
                              !(par_ok && type_ok) ? mcpah_pkg::SW_BAD_P :
                              mcpah_pkg::SW_OK;
   wire logic dec_ok = dec_sw == mcpah_pkg::SW_OK;
   wire logic wr_ins = ins_d0 || ins_d1;

   // Opcode mapping for the selected family
   wire mcpah_pkg::mcpah_op_t dec_op =
      is_sel ? mcpah_pkg::OP_POWER_CYCLE :
      is_pw ? mcpah_pkg::OP_PW_BYTE :
      (is_auth && ins_as) ? mcpah_pkg::OP_AUTH_START :
      is_auth ? mcpah_pkg::OP_AUTH_FINISH :
      is_fuse ? (wr_ins ? mcpah_pkg::OP_FUSE_WRITE : mcpah_pkg::OP_FUSE_READ) :
      ins_b1 ? mcpah_pkg::OP_CFG_READ :
      ins_d1 ? mcpah_pkg::OP_CFG_WRITE :
      ins_d0 ? mcpah_pkg::OP_USER_WRITE :
      mcpah_pkg::OP_USER_READ;
   wire logic [7:0] dec_n = is_sel ? mcpah_pkg::LEN_SELECT : hdr_len;
   wire logic dec_mem = is_wr_z || is_pw || is_auth;
   // Zone byte only for zoned memory; fuse access ignores it
   wire logic [mcpah_pkg::ADDR_W-1:0] dec_base =
      is_fuse ? {3'h0, hdr_p2} :
      fam_t ? {1'b0, hdr_p1[1:0], hdr_p2} :
      (is_pw || is_auth || is_sel) ? {mcpah_pkg::ADDR_W{1'b0}} :
      {hdr_p1[2:0], hdr_p2};
   wire logic is_read_op = (card_op == mcpah_pkg::OP_USER_READ) ||
                           (card_op == mcpah_pkg::OP_CFG_READ) ||
                           (card_op == mcpah_pkg::OP_FUSE_READ);
   wire logic job_last = cnt == (job_n - 8'h01);
   wire logic [mcpah_pkg::ADDR_W-1:0] next_addr = job_base + {3'h0, cnt};
   wire mcpah_pkg::mcpah_family_t sel_family = (data0 == mcpah_pkg::TYPE_ZONED) ?
                                               mcpah_pkg::FAM_ZONED : mcpah_pkg::FAM_TENBIT;

   // -------------------------------------------------------------
   // Receive frame capture
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rx_idx <= 9'h000;
         hdr_cla <= 8'h00;
         hdr_ins <= 8'h00;
         hdr_p1 <= 8'h00;
         hdr_p2 <= 8'h00;
         hdr_len <= 8'h00;
         data0 <= 8'h00;
      end else if (ce) begin
         if (state == S_SW2 && rsp_ready) begin
            rx_idx <= 9'h000;
         end else if (state == S_RX && accept) begin
            // Overlong frames stop counting and fail the length check
            if (rx_idx <= mcpah_pkg::RX_IDX_MAX) begin
               rx_idx <= rx_idx + 9'h001;
            end
            if (rx_idx == mcpah_pkg::IDX_CLA) hdr_cla <= cmd_data;
            if (rx_idx == mcpah_pkg::IDX_INS) hdr_ins <= cmd_data;
            if (rx_idx == mcpah_pkg::IDX_P1) hdr_p1 <= cmd_data;
            if (rx_idx == mcpah_pkg::IDX_P2) hdr_p2 <= cmd_data;
            if (rx_idx == mcpah_pkg::IDX_LEN) hdr_len <= cmd_data;
            if (rx_idx == mcpah_pkg::HDR_LEN) data0 <= cmd_data;
         end
      end
   end

   // -------------------------------------------------------------
   // Sequencer: card steps, reply bytes, status word
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= S_RX;
         cmd_ready <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_last <= 1'b0;
         card_req <= 1'b0;
         card_op <= mcpah_pkg::OP_NONE;
         card_addr <= {mcpah_pkg::ADDR_W{1'b0}};
         card_wdata <= 8'h00;
         card_pw_read <= 1'b0;
         card_pw_set <= 3'h0;
         card_pw_secure <= 1'b0;
         card_family <= mcpah_pkg::FAM_NONE;
         page_size <= mcpah_pkg::PAGE_DEFAULT;
         retry_counter <= 8'h00;
         pw_verified <= 1'b0;
         pw_locked <= 1'b0;
         cnt <= 8'h00;
         job_n <= 8'h00;
         job_base <= {mcpah_pkg::ADDR_W{1'b0}};
         job_mem <= 1'b0;
         sw <= mcpah_pkg::SW_OK;
         pend_family <= mcpah_pkg::FAM_NONE;
      end else if (ce) begin
         case (state)
            S_RX: begin
               if (accept && cmd_last) begin
                  cmd_ready <= 1'b0;
                  state <= S_DECODE;
               end
            end
            S_DECODE: begin
               cnt <= 8'h00;
               job_n <= dec_n;
               job_base <= dec_base;
               job_mem <= dec_mem;
               card_op <= dec_op;
               card_addr <= dec_base;
               pend_family <= sel_family;
               sw <= dec_sw;
               // Selector nibble: access kind, set number, secure code
               card_pw_read <= data0[mcpah_pkg::PW_READ_BIT];
               card_pw_set <= data0[2:0];
               card_pw_secure <= data0[3:0] == mcpah_pkg::PW_SEL_SECURE;
               if (!dec_ok || dec_n == 8'h00) begin
                  state <= S_STATUS;
               end else if (dec_mem) begin
                  state <= S_FETCH;
               end else begin
                  card_req <= 1'b1;
                  state <= S_CARD;
               end
            end
            S_FETCH: begin
               state <= S_LOAD;
            end
            S_LOAD: begin
               card_wdata <= buf_rdata;
               card_addr <= next_addr;
               card_req <= 1'b1;
               state <= S_CARD;
            end
            S_CARD: begin
               if (card_ack) begin
                  card_req <= 1'b0;
                  cnt <= cnt + 8'h01;
                  if (card_op == mcpah_pkg::OP_POWER_CYCLE) begin
                     // Power cycle is always followed by a card reset
                     card_op <= mcpah_pkg::OP_RESET;
                     card_req <= 1'b1;
                     cnt <= 8'h00;
                  end else if (card_op == mcpah_pkg::OP_RESET) begin
                     card_family <= pend_family;
                     if (pend_family == mcpah_pkg::FAM_ZONED) begin
                        page_size <= mcpah_pkg::PAGE_ZONED;
                     end
                     state <= S_STATUS;
                  end else if (is_read_op) begin
                     rsp_valid <= 1'b1;
                     rsp_data <= card_rdata;
                     rsp_last <= 1'b0;
                     state <= S_OUT;
                  end else if (job_last) begin
                     if (card_op == mcpah_pkg::OP_PW_BYTE) begin
                        retry_counter <= card_rdata;
                        sw <= {mcpah_pkg::SW1_OK, card_rdata};
                        pw_verified <= card_rdata == mcpah_pkg::CNT_SUCCESS;
                        pw_locked <= card_rdata == mcpah_pkg::CNT_LOCKED;
                     end
                     state <= S_STATUS;
                  end else begin
                     state <= S_FETCH;
                  end
               end
            end
            S_OUT: begin
               if (rsp_ready) begin
                  rsp_valid <= 1'b0;
                  if (cnt == job_n) begin
                     state <= S_STATUS;
                  end else begin
                     card_addr <= next_addr;
                     card_req <= 1'b1;
                     state <= S_CARD;
                  end
               end
            end
            S_STATUS: begin
               rsp_valid <= 1'b1;
               rsp_data <= sw[15:8];
               rsp_last <= 1'b0;
               state <= S_SW1;
            end
            S_SW1: begin
               if (rsp_ready) begin
                  rsp_data <= sw[7:0];
                  rsp_last <= 1'b1;
                  state <= S_SW2;
               end
            end
            S_SW2: begin
               if (rsp_ready) begin
                  rsp_valid <= 1'b0;
                  rsp_last <= 1'b0;
                  cmd_ready <= 1'b1;
                  state <= S_RX;
               end
            end
            default: begin
               state <= S_RX;
            end
         endcase
         // Card removal drops the family and page size back to defaults
         if (!card_present) begin
            card_family <= mcpah_pkg::FAM_NONE;
            page_size <= mcpah_pkg::PAGE_DEFAULT;
         end
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset || !ce);

   sequence s_power_done;
      card_req && card_ack && (card_op == mcpah_pkg::OP_POWER_CYCLE);
   endsequence

   sequence s_reset_issued;
      card_req && (card_op == mcpah_pkg::OP_RESET);
   endsequence

   a_power_then_reset: assert property (s_power_done |=> s_reset_issued)
      else $error("power cycle not followed by card reset");

   a_zoned_page_size: assert property ((state == S_CARD) && card_ack && card_present &&
      (card_op == mcpah_pkg::OP_RESET) && (pend_family == mcpah_pkg::FAM_ZONED)
      |=> (page_size == mcpah_pkg::PAGE_ZONED) && (card_family == mcpah_pkg::FAM_ZONED))
      else $error("zoned select did not set page size");

   a_tenbit_family: assert property ((state == S_CARD) && card_ack && card_present &&
      (card_op == mcpah_pkg::OP_RESET) && (pend_family == mcpah_pkg::FAM_TENBIT)
      |=> card_family == mcpah_pkg::FAM_TENBIT)
      else $error("ten-bit select did not set family");

   // First cycle of the low byte only; a stalling sink holds it for longer
   a_status_tail: assert property (rsp_valid && rsp_last && !$past(rsp_last) |->
      rsp_data == sw[7:0] && $past(rsp_data) == sw[15:8])
      else $error("reply does not end with status word");

   a_fuse_read_op: assert property ((state == S_DECODE) && dec_ok && fam_z && ins_b1 &&
      (hdr_p2 == mcpah_pkg::FUSE_ADDR) |=> card_op == mcpah_pkg::OP_FUSE_READ)
      else $error("fuse read not decoded");

   a_user_read_op: assert property ((state == S_DECODE) && dec_ok && fam_z && ins_b0
      |=> card_op == mcpah_pkg::OP_USER_READ && card_addr[10:8] == $past(hdr_p1[2:0]))
      else $error("zoned user read decode or address wrong");

   a_cfg_write_op: assert property ((state == S_DECODE) && dec_ok && fam_z && ins_d1 &&
      (hdr_p2 != mcpah_pkg::FUSE_ADDR) |=> card_op == mcpah_pkg::OP_CFG_WRITE)
      else $error("configuration write not decoded");

   a_tenbit_addr: assert property ((state == S_DECODE) && dec_ok && fam_t && ins_b0
      |=> card_addr == {1'b0, $past(hdr_p1[1:0]), $past(hdr_p2)})
      else $error("ten-bit address wrong");

   a_read_byte_out: assert property ((state == S_CARD) && card_ack && is_read_op
      |=> rsp_valid && !rsp_last && rsp_data == $past(card_rdata))
      else $error("read byte not forwarded");

   a_pw_reply: assert property ((state == S_CARD) && card_ack && job_last &&
      (card_op == mcpah_pkg::OP_PW_BYTE) |=> sw == {mcpah_pkg::SW1_OK, $past(card_rdata)}
      ##1 rsp_valid && rsp_data == mcpah_pkg::SW1_OK)
      else $error("verify reply wrong");

   a_refused_untouched: assert property ((state == S_DECODE) && !dec_ok
      |=> !card_req [*2] ##0 rsp_valid)
      else $error("refused command touched the card");

endmodule : mcpah_top

// ===== test/mcpah_card_model.sv
module mcpah_card_model (
   input wire logic ref_clk,
   input wire logic card_req,
   input wire mcpah_pkg::mcpah_op_t card_op,
   input wire logic [mcpah_pkg::ADDR_W-1:0] card_addr,
   input wire logic [7:0] pw_cnt,
   output logic card_ack,
   output logic [7:0] card_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // Card responder
   // ----------------------------------------
   int waited = 0;
   logic slow = 1'b0;
   initial card_ack = 1'b0;
   initial card_rdata = 8'h00;
   // Prompt and slow answers alternate; data churns between acks so stale reads show
   always @(posedge ref_clk) begin
      card_ack <= #1 1'b0;
      card_rdata <= #1 ~card_rdata;
      waited = card_req ? waited + 1 : 0;
      if (card_req && !card_ack && waited > (slow ? 3 : 0)) begin
         card_ack <= #1 1'b1;
         card_rdata <= #1 (card_op == mcpah_pkg::OP_PW_BYTE) ? pw_cnt :
            card_addr[7:0] + {card_addr[10:8], 5'h11};
         waited = 0;
         slow = ~slow;
      end
   end
endmodule : mcpah_card_model

// ===== test/test_memory_card_pseudo_apdu_handler.sv
module test_memory_card_pseudo_apdu_handler;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {
      logic [7:0] ins, p1, p2, lc, d0;
      mcpah_pkg::mcpah_op_t op;
      logic [15:0] sw;
   } mcpah_row_t;
   logic ref_clk = 1'b0, reset = 1'b1, ce = 1'b1, card_present = 1'b1;
   logic cmd_valid = 1'b0, cmd_last = 1'b0, rsp_ready = 1'b0;
   logic [7:0] cmd_data = 8'h00, pw_cnt = 8'hFF;
   logic cmd_ready, rsp_valid, rsp_last, card_req, card_ack, card_pw_read, card_pw_secure;
   logic pw_verified, pw_locked;
   logic [7:0] rsp_data, card_wdata, card_rdata, page_size, retry_counter;
   logic [2:0] card_pw_set;
   logic [mcpah_pkg::ADDR_W-1:0] card_addr;
   mcpah_pkg::mcpah_op_t card_op;
   mcpah_pkg::mcpah_family_t card_family;
   int n_errors = 0, n_compared = 0, cyc = 0, at_last = 0;
   logic [7:0] rq[$], wq[$];
   mcpah_pkg::mcpah_op_t oq[$];
   mcpah_row_t rows[12] = '{
      '{8'hA4, 8'h00, 8'h00, 8'h01, 8'h04, mcpah_pkg::OP_POWER_CYCLE, 16'h9000},
      '{8'hB0, 8'h03, 8'h10, 8'h02, 8'h00, mcpah_pkg::OP_USER_READ, 16'h9000},
      '{8'hB1, 8'hF9, 8'h20, 8'h01, 8'h00, mcpah_pkg::OP_CFG_READ, 16'h9000},
      '{8'hB1, 8'h05, 8'h80, 8'h01, 8'h00, mcpah_pkg::OP_FUSE_READ, 16'h9000},
      '{8'hD0, 8'h00, 8'h05, 8'h02, 8'h33, mcpah_pkg::OP_USER_WRITE, 16'h9000},
      '{8'hD1, 8'h00, 8'h80, 8'h01, 8'h44, mcpah_pkg::OP_FUSE_WRITE, 16'h9000},
      '{8'hD1, 8'h01, 8'h20, 8'h01, 8'h55, mcpah_pkg::OP_CFG_WRITE, 16'h9000},
      '{8'h84, 8'h00, 8'h00, 8'h08, 8'h01, mcpah_pkg::OP_AUTH_START, 16'h9000},
      '{8'h82, 8'h00, 8'h00, 8'h08, 8'h09, mcpah_pkg::OP_AUTH_FINISH, 16'h9000},
      '{8'h55, 8'h00, 8'h00, 8'h00, 8'h00, mcpah_pkg::OP_NONE, 16'h6D00},
      '{8'hA4, 8'h00, 8'h00, 8'h01, 8'h07, mcpah_pkg::OP_NONE, 16'h6A86},
      '{8'hA4, 8'h00, 8'h00, 8'h01, 8'h05, mcpah_pkg::OP_POWER_CYCLE, 16'h9000}
   };
   mcpah_top mcpah_top_i (
      .ref_clk(ref_clk), .reset(reset), .ce(ce), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
      .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_last(rsp_last), .rsp_ready(rsp_ready), .card_present(card_present),
      .card_req(card_req), .card_op(card_op), .card_addr(card_addr), .card_wdata(card_wdata),
      .card_ack(card_ack), .card_rdata(card_rdata), .card_pw_read(card_pw_read),
      .card_pw_set(card_pw_set), .card_pw_secure(card_pw_secure), .card_family(card_family),
      .page_size(page_size), .retry_counter(retry_counter), .pw_verified(pw_verified),
      .pw_locked(pw_locked)
   );
   mcpah_card_model mcpah_card_model_i (
      .ref_clk(ref_clk), .card_req(card_req), .card_op(card_op), .card_addr(card_addr),
      .pw_cnt(pw_cnt), .card_ack(card_ack), .card_rdata(card_rdata)
   );
   // ----------------------------------------
   // Clock, reply sink, monitor and hang guard
   // ----------------------------------------
   always #5 ref_clk = ~ref_clk;
   // Sink stalls every other cycle so reply bytes must hold
   always @(posedge ref_clk) begin
      rsp_ready <= #1 ~rsp_ready;
      cyc++;
      if (rsp_valid && rsp_ready) rq.push_back(rsp_data);
      if (rsp_valid && rsp_ready && rsp_last) at_last = rq.size();
      if (card_req && card_ack) oq.push_back(card_op);
      if (card_req && card_ack) wq.push_back(card_wdata);
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end
   task tick();
      @(posedge ref_clk);
      #1;
   endtask : tick
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task conclude();
      if (n_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   // ----------------------------------------
   // One frame out, whole reply back, then compare
   // ----------------------------------------
   task run(input mcpah_row_t r);
      logic [7:0] f[$];
      logic [10:0] a, b;
      int i, nrd, nops;
      f = {8'hFF, r.ins, r.p1, r.p2, r.lc};
      for (i = 0; i < ((r.ins[7:4] == 4'hB) ? 0 : r.lc); i++) f.push_back(r.d0 + 8'(i));
      nrd = (r.op inside {mcpah_pkg::OP_USER_READ, mcpah_pkg::OP_CFG_READ,
         mcpah_pkg::OP_FUSE_READ}) ? r.lc : 0;
      nops = (r.op == mcpah_pkg::OP_NONE) ? 0 : (r.op == mcpah_pkg::OP_POWER_CYCLE) ? 2 : r.lc;
      a = (r.ins == 8'hB1 && r.p2 == 8'h80) ? 11'h080 : {r.p1[2:0], r.p2};
      rq = {};
      oq = {};
      wq = {};
      at_last = 0;
      foreach (f[k]) begin
         cmd_valid = 1'b1;
         cmd_data = f[k];
         cmd_last = (k == f.size() - 1);
         while (cmd_ready !== 1'b1) tick();
         tick();
      end
      cmd_valid = 1'b0;
      cmd_last = 1'b0;
      for (i = 0; i < 400 && (rq.size() < nrd + 2 || cmd_ready !== 1'b1); i++) tick();
      chk(16'(rq.size()), 16'(nrd + 2));
      chk(16'(at_last), 16'(nrd + 2));
      for (i = 0; i < nrd; i++) begin
         b = a + 11'(i);
         chk(rq[i], b[7:0] + {b[10:8], 5'h11});
      end
      chk({rq[nrd], rq[nrd + 1]}, r.sw);
      chk(16'(oq.size()), 16'(nops));
      if (nops > 0) chk(16'(oq[0]), 16'(r.op));
      // Card bytes of writes, password and authentication follow the frame's data
      if (nrd == 0 && r.op != mcpah_pkg::OP_POWER_CYCLE) begin
         foreach (wq[j]) chk(wq[j], f[5 + j]);
      end
   endtask : run
   // Table first, then password, removal and a second reset by hand
   initial begin
      repeat (4) tick();
      reset = 1'b0;
      chk({cmd_ready, page_size}, 9'h108);
      foreach (rows[n]) run(rows[n]);
      run('{8'hB0, 8'h02, 8'h34, 8'h01, 8'h00, mcpah_pkg::OP_USER_READ, 16'h9000});
      chk({page_size, 6'h00, card_family}, {8'h10, 6'h00, mcpah_pkg::FAM_TENBIT});
      run(rows[0]);
      run('{8'h20, 8'h00, 8'h00, 8'h04, 8'h01, mcpah_pkg::OP_PW_BYTE, 16'h90FF});
      chk({pw_verified, pw_locked, retry_counter}, 10'h2FF);
      pw_cnt = 8'h00;
      run('{8'h20, 8'h00, 8'h00, 8'h04, 8'h07, mcpah_pkg::OP_PW_BYTE, 16'h9000});
      chk({card_pw_secure, pw_verified, pw_locked}, 3'h5);
      pw_cnt = 8'h3C;
      run('{8'h20, 8'h00, 8'h00, 8'h04, 8'h0B, mcpah_pkg::OP_PW_BYTE, 16'h903C});
      chk({card_pw_read, card_pw_set, card_pw_secure, pw_verified, pw_locked}, 7'h58);
      ce = 1'b0;
      card_present = 1'b0;
      tick();
      tick();
      chk({page_size, 6'h00, card_family}, {8'h10, 6'h00, mcpah_pkg::FAM_ZONED});
      ce = 1'b1;
      tick();
      chk({page_size, 6'h00, card_family}, {8'h08, 6'h00, mcpah_pkg::FAM_NONE});
      run('{8'hB0, 8'h00, 8'h00, 8'h01, 8'h00, mcpah_pkg::OP_NONE, 16'h6985});
      card_present = 1'b1;
      reset = 1'b1;
      tick();
      reset = 1'b0;
      chk({cmd_ready, rsp_valid, card_req, page_size}, 11'h408);
      conclude();
   end
endmodule : test_memory_card_pseudo_apdu_handler
